// ==== inc/pcfs_pkg.sv ====
// Purpose: Shared constants, types and decode for the port C pin function select block
// Assumes: AHB-Lite slave, 32-bit data, one register per aligned word
// Notes: Upper register covers pins 14..8, lower register covers pins 7..0
//
// Overview of operation
// - Pin 14 select code 00 is generic I/O, 01 is one-shot output H, 10 and 11 are reserved.
// - Pin 13 select code 00 is generic I/O, 01 is one-shot output G, 10 and 11 are reserved.
// - Pin 12 select code 00 is generic I/O, 01 is one-shot output F, 10 is DMA ack one.
// - Pin 11 select code 00 is generic I/O, 01 is one-shot output E, 10 is DMA ack zero.
// - Pin 10 select code 00 is generic I/O, 01 is one-shot output D, 10 and 11 are reserved.
// - Pin 9 select code 00 is generic I/O, 01 is one-shot output C, 10 and 11 are reserved.
// - Pin 8 select code 00 is generic I/O, 01 is one-shot output B, 10 and 11 are reserved.
// - After reset every select field of pins 8 to 14 holds 00, so those pins start as I/O.
// - Lower register holds pin 7 at 15:14, pin 6 at 13:12, pin 5 at bit 10, pin 4 at bit 8.
// - Lower bits 11,9,7,5,3,1 are read-only ones; bits 6,4,2,0 and the pin 4 bit reset to 1.
package pcfs_pkg;
    // ==========================================================
    // Sizes
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int ADDR_W = 12;
    localparam int NUM_PINS = 15;
    localparam int UP_LO = 8;
    localparam int UP_N = 7;
    localparam int FIELD_W = 2;

    // ==========================================================
    // Register map
    localparam logic [ADDR_W-1:0] UPPER_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] LOWER_OFS = 12'h004;
    localparam logic [REG_W-1:0] UPPER_RST = 16'hC000;
    localparam logic [REG_W-1:0] UPPER_RO = 16'hC000;
    localparam logic [REG_W-1:0] LOWER_RST = 16'h0BFF;
    localparam logic [REG_W-1:0] LOWER_RO = 16'h0AAA;

    // Lower register field positions
    localparam int PIN7_LSB = 14;
    localparam int PIN6_LSB = 12;
    localparam int PIN5_BIT = 10;
    localparam int PIN4_BIT = 8;

    // ==========================================================
    // Select codes and special pins
    localparam logic [1:0] SEL_GPIO = 2'h0;
    localparam logic [1:0] SEL_ONESHOT = 2'h1;
    localparam logic [1:0] SEL_DMA = 2'h2;
    localparam logic [1:0] SEL_RSVD = 2'h3;
    localparam int PIN_DMA1 = 12;
    localparam int PIN_DMA0 = 11;
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    typedef enum {FN_GPIO, FN_ONESHOT, FN_DMA_ACK} pcfs_fn_t;

    // Reserved codes fall back to generic I/O
    function automatic pcfs_fn_t pcfs_decode(input logic [1:0] code, input logic has_dma);
        pcfs_fn_t fn;
        fn = FN_GPIO;
        if (code == SEL_ONESHOT) begin
            fn = FN_ONESHOT;
        end else if (code == SEL_DMA && has_dma) begin
            fn = FN_DMA_ACK;
        end
        return fn;
    endfunction

    // Upper field of a pin in the upper register
    function automatic logic [1:0] pcfs_up_field(input logic [REG_W-1:0] r, input int pin);
        return r[FIELD_W*(pin-UP_LO) +: FIELD_W];
    endfunction
endpackage

// ==== inc/pcfs_sel_if.sv ====
// Purpose: Carrier between register logic and the upper pin multiplexer
// Assumes: Single clock, combinational multiplexer
// Notes: Index 0 of each per-pin vector is pin 8; index 0 of dma_ack is DMA ack zero
`timescale 1ns/1ps
interface pcfs_sel_if;
    import pcfs_pkg::*;
    logic [REG_W-1:0] upper_sel;
    logic [UP_N-1:0] oneshot;
    logic [1:0] dma_ack;
    logic [UP_N-1:0] gpio_out;
    logic [UP_N-1:0] gpio_oe;
    logic [UP_N-1:0] mux_out;
    logic [UP_N-1:0] mux_oe;

    modport ctl (
        output upper_sel, oneshot, dma_ack, gpio_out, gpio_oe,
        input mux_out, mux_oe
    );
    modport mux (
        input upper_sel, oneshot, dma_ack, gpio_out, gpio_oe,
        output mux_out, mux_oe
    );
endinterface

// ==== design/pcfs_pin_sync.sv ====
// Purpose: Two-stage synchroniser for pad inputs
// Assumes: Pads are asynchronous to mclk
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module pcfs_pin_sync
    import pcfs_pkg::*;
#(
    parameter int W = NUM_PINS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Data
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_sync
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } pcfs_sync_state_t;

    pcfs_sync_state_t s_reg;
    pcfs_sync_state_t s_next;

    always_comb begin
        s_next.stage1 = pin_in;
        s_next.stage2 = s_reg.stage1;
        if (!rst_b) begin
            s_next = '0;
        end
    end

    always_ff @(posedge mclk) begin
        s_reg <= s_next;
    end

    assign pin_sync = s_reg.stage2;
endmodule

// ==== design/pcfs_upper_mux.sv ====
// Purpose: Function multiplexer for pins 14..8
// Assumes: All sources on mclk
// Notes: Purely combinational; the top registers the result
`timescale 1ns/1ps
module pcfs_upper_mux
    import pcfs_pkg::*;
(
    // Select and sources
    pcfs_sel_if.mux sel
);
    // ==========================================================
    // Per-pin decode
    for (genvar i = 0; i < UP_N; i++) begin : g_pin
        localparam int PIN = i + UP_LO;
        localparam bit HAS_DMA = (PIN == PIN_DMA1) || (PIN == PIN_DMA0);
        localparam int DMA_IDX = (PIN == PIN_DMA1) ? 1 : 0;
        pcfs_fn_t fn;

        assign fn = pcfs_decode(pcfs_up_field(sel.upper_sel, PIN), HAS_DMA);

        // Reserved codes land on generic I/O here
        assign sel.mux_out[i] = (fn == FN_ONESHOT) ? sel.oneshot[i] :
                                (fn == FN_DMA_ACK) ? sel.dma_ack[DMA_IDX] :
                                sel.gpio_out[i];
        assign sel.mux_oe[i] = (fn == FN_GPIO) ? sel.gpio_oe[i] : 1'b1;
    end
endmodule

// ==== design/pcfs_top.sv ====
// Purpose: Port C pin function select registers and pad multiplexing
// Assumes: AHB-Lite single word transfers; all on-chip sources on mclk
// Notes: Zero wait states; lower pin functions are decoded outside this block
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module pcfs_top
    import pcfs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [DATA_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    // Port data logic
    input wire logic [NUM_PINS-1:0] gpio_out,
    input wire logic [NUM_PINS-1:0] gpio_oe,
    output logic [NUM_PINS-1:0] gpio_in,
    // Timer and DMA sources
    input wire logic oneshot_out_b,
    input wire logic oneshot_out_c,
    input wire logic oneshot_out_d,
    input wire logic oneshot_out_e,
    input wire logic oneshot_out_f,
    input wire logic oneshot_out_g,
    input wire logic oneshot_out_h,
    input wire logic dma_ack_out_zero,
    input wire logic dma_ack_out_one,
    // Lower pin select fields for the lower function logic
    output logic [REG_W-1:0] lower_select,
    // Pads
    input wire logic [NUM_PINS-1:0] pad_in,
    output logic [NUM_PINS-1:0] pad_out,
    output logic [NUM_PINS-1:0] pad_oe
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [REG_W-1:0] upper_sel;
        logic [REG_W-1:0] lower_sel;
        logic wr_pend;
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] rdata;
        logic ready;
        logic [1:0] resp;
        logic [NUM_PINS-1:0] pad_out;
        logic [NUM_PINS-1:0] pad_oe;
    } pcfs_top_state_t;

    localparam pcfs_top_state_t STATE_RST = '{
        upper_sel: UPPER_RST,
        lower_sel: LOWER_RST,
        wr_pend: 1'b0,
        wr_addr: '0,
        rdata: '0,
        ready: 1'b1,
        resp: HRESP_OKAY,
        pad_out: '0,
        pad_oe: '0
    };

    pcfs_top_state_t s_reg;
    pcfs_top_state_t s_next;
    logic accept;

    pcfs_sel_if sel ();

    // ==========================================================
    // Helpers
    // Read-only bits are forced high on every store, never stored from the bus
    function automatic logic [REG_W-1:0] merge_ro(input logic [REG_W-1:0] wd,
                                                  input logic [REG_W-1:0] ro);
        return (wd & ~ro) | ro;
    endfunction

    function automatic logic [DATA_W-1:0] read_word(input pcfs_top_state_t st,
                                                    input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] w;
        w = '0;
        if (a == UPPER_OFS) begin
            w[REG_W-1:0] = st.upper_sel;
        end else if (a == LOWER_OFS) begin
            w[REG_W-1:0] = st.lower_sel;
        end
        return w;
    endfunction

    // ==========================================================
    // Submodules
    assign sel.upper_sel = s_reg.upper_sel;
    assign sel.oneshot = {oneshot_out_h, oneshot_out_g, oneshot_out_f, oneshot_out_e,
                          oneshot_out_d, oneshot_out_c, oneshot_out_b};
    assign sel.dma_ack = {dma_ack_out_one, dma_ack_out_zero};
    assign sel.gpio_out = gpio_out[NUM_PINS-1:UP_LO];
    assign sel.gpio_oe = gpio_oe[NUM_PINS-1:UP_LO];

    pcfs_upper_mux u_mux (
        .sel(sel.mux)
    );

    pcfs_pin_sync #(
        .W(NUM_PINS)
    ) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .pin_in(pad_in),
        .pin_sync(gpio_in)
    );

    // ==========================================================
    // Next state
    assign accept = hsel && hready && htrans[1];

    always_comb begin
        s_next = s_reg;
        s_next.ready = 1'b1;
        s_next.resp = HRESP_OKAY;
        // Data phase of a pending write
        if (s_reg.wr_pend) begin
            if (s_reg.wr_addr == UPPER_OFS) begin
                s_next.upper_sel = merge_ro(hwdata[REG_W-1:0], UPPER_RO);
            end else if (s_reg.wr_addr == LOWER_OFS) begin
                s_next.lower_sel = merge_ro(hwdata[REG_W-1:0], LOWER_RO);
            end
        end
        s_next.wr_pend = accept && hwrite;
        s_next.wr_addr = haddr[ADDR_W-1:0];
        // Read sees a write finishing in the same cycle
        if (accept && !hwrite) begin
            s_next.rdata = read_word(s_next, haddr[ADDR_W-1:0]);
        end
        // Upper pins from the function mux, lower pins stay on port logic
        s_next.pad_out = {sel.mux_out, gpio_out[UP_LO-1:0]};
        s_next.pad_oe = {sel.mux_oe, gpio_oe[UP_LO-1:0]};
        if (!rst_b) begin
            s_next = STATE_RST;
        end
    end

    always_ff @(posedge mclk) begin
        s_reg <= s_next;
    end

    // ==========================================================
    // Outputs
    assign hrdata = s_reg.rdata;
    assign hreadyout = s_reg.ready;
    assign hresp = s_reg.resp;
    assign lower_select = s_reg.lower_sel;
    assign pad_out = s_reg.pad_out;
    assign pad_oe = s_reg.pad_oe;

    // ==========================================================
    // Assertions
    sequence s_wr_lower;
        accept && hwrite && haddr[ADDR_W-1:0] == LOWER_OFS ##1 1'b1;
    endsequence

    sequence s_wr_upper;
        accept && hwrite && haddr[ADDR_W-1:0] == UPPER_OFS ##1 1'b1;
    endsequence

    sequence s_rd_lower;
        accept && !hwrite && haddr[ADDR_W-1:0] == LOWER_OFS;
    endsequence

    property p_pin14_oneshot;
        @(posedge mclk) disable iff (!rst_b)
        pcfs_up_field(s_reg.upper_sel, 14) == SEL_ONESHOT
        |=> pad_out[14] == $past(oneshot_out_h) && pad_oe[14];
    endproperty
    a_pin14_oneshot: assert property (p_pin14_oneshot)
        else $error("pin 14 not driven by one-shot H");

    property p_pin13_reserved;
        @(posedge mclk) disable iff (!rst_b)
        pcfs_up_field(s_reg.upper_sel, 13) == SEL_DMA
        |=> pad_out[13] == $past(gpio_out[13]) && pad_oe[13] == $past(gpio_oe[13]);
    endproperty
    a_pin13_reserved: assert property (p_pin13_reserved)
        else $error("pin 13 reserved code not on generic I/O");

    property p_pin12_dma;
        @(posedge mclk) disable iff (!rst_b)
        pcfs_up_field(s_reg.upper_sel, 12) == SEL_DMA
        |=> pad_out[12] == $past(dma_ack_out_one) && pad_oe[12];
    endproperty
    a_pin12_dma: assert property (p_pin12_dma)
        else $error("pin 12 not driven by DMA ack one");

    property p_pin11_dma;
        @(posedge mclk) disable iff (!rst_b)
        pcfs_up_field(s_reg.upper_sel, 11) == SEL_DMA
        |=> pad_out[11] == $past(dma_ack_out_zero) && pad_oe[11];
    endproperty
    a_pin11_dma: assert property (p_pin11_dma)
        else $error("pin 11 not driven by DMA ack zero");

    // Release edge excluded: pads there still carry the reset drive
    property p_pin10_gpio;
        @(posedge mclk) disable iff (!rst_b)
        rst_b && pcfs_up_field(s_reg.upper_sel, 10) == SEL_GPIO
        |=> pad_out[10] == $past(gpio_out[10]) && pad_oe[10] == $past(gpio_oe[10]);
    endproperty
    a_pin10_gpio: assert property (p_pin10_gpio)
        else $error("pin 10 not on generic I/O");

    property p_pin9_reserved;
        @(posedge mclk) disable iff (!rst_b)
        pcfs_up_field(s_reg.upper_sel, 9) == SEL_RSVD
        |=> pad_out[9] == $past(gpio_out[9]) && pad_oe[9] == $past(gpio_oe[9]);
    endproperty
    a_pin9_reserved: assert property (p_pin9_reserved)
        else $error("pin 9 reserved code not on generic I/O");

    property p_pin8_oneshot;
        @(posedge mclk) disable iff (!rst_b)
        pcfs_up_field(s_reg.upper_sel, 8) == SEL_ONESHOT
        |=> pad_out[8] == $past(oneshot_out_b) && pad_oe[8];
    endproperty
    a_pin8_oneshot: assert property (p_pin8_oneshot)
        else $error("pin 8 not driven by one-shot B");

    property p_pin13_oneshot;
        @(posedge mclk) disable iff (!rst_b)
        pcfs_up_field(s_reg.upper_sel, 13) == SEL_ONESHOT
        |=> pad_out[13] == $past(oneshot_out_g) && pad_oe[13];
    endproperty
    a_pin13_oneshot: assert property (p_pin13_oneshot)
        else $error("pin 13 not driven by one-shot G");

    property p_pin12_oneshot;
        @(posedge mclk) disable iff (!rst_b)
        pcfs_up_field(s_reg.upper_sel, 12) == SEL_ONESHOT
        |=> pad_out[12] == $past(oneshot_out_f) && pad_oe[12];
    endproperty
    a_pin12_oneshot: assert property (p_pin12_oneshot)
        else $error("pin 12 not driven by one-shot F");

    property p_pin11_reserved;
        @(posedge mclk) disable iff (!rst_b)
        pcfs_up_field(s_reg.upper_sel, 11) == SEL_RSVD
        |=> pad_out[11] == $past(gpio_out[11]) && pad_oe[11] == $past(gpio_oe[11]);
    endproperty
    a_pin11_reserved: assert property (p_pin11_reserved)
        else $error("pin 11 reserved code not on generic I/O");

    // No acknowledge on pin 10, so code 10 must not leave generic I/O
    property p_pin10_reserved;
        @(posedge mclk) disable iff (!rst_b)
        pcfs_up_field(s_reg.upper_sel, 10) == SEL_DMA
        |=> pad_out[10] == $past(gpio_out[10]) && pad_oe[10] == $past(gpio_oe[10]);
    endproperty
    a_pin10_reserved: assert property (p_pin10_reserved)
        else $error("pin 10 reserved code not on generic I/O");

    property p_pin9_oneshot;
        @(posedge mclk) disable iff (!rst_b)
        pcfs_up_field(s_reg.upper_sel, 9) == SEL_ONESHOT
        |=> pad_out[9] == $past(oneshot_out_c) && pad_oe[9];
    endproperty
    a_pin9_oneshot: assert property (p_pin9_oneshot)
        else $error("pin 9 not driven by one-shot C");

    property p_pin8_reserved;
        @(posedge mclk) disable iff (!rst_b)
        pcfs_up_field(s_reg.upper_sel, 8) == SEL_DMA
        |=> pad_out[8] == $past(gpio_out[8]) && pad_oe[8] == $past(gpio_oe[8]);
    endproperty
    a_pin8_reserved: assert property (p_pin8_reserved)
        else $error("pin 8 reserved code not on generic I/O");

    property p_reset_upper;
        @(posedge mclk) disable iff (!rst_b)
        $rose(rst_b) |-> s_reg.upper_sel == UPPER_RST && s_reg.lower_sel == LOWER_RST;
    endproperty
    a_reset_upper: assert property (p_reset_upper)
        else $error("select registers not at reset value after reset");

    property p_lower_layout;
        @(posedge mclk) disable iff (!rst_b)
        s_wr_lower |=> s_reg.lower_sel[PIN7_LSB +: FIELD_W] == $past(hwdata[PIN7_LSB +: FIELD_W])
            && s_reg.lower_sel[PIN6_LSB +: FIELD_W] == $past(hwdata[PIN6_LSB +: FIELD_W])
            && s_reg.lower_sel[PIN5_BIT] == $past(hwdata[PIN5_BIT])
            && s_reg.lower_sel[PIN4_BIT] == $past(hwdata[PIN4_BIT]);
    endproperty
    a_lower_layout: assert property (p_lower_layout)
        else $error("lower select field not stored at its position");

    property p_lower_ro_read;
        @(posedge mclk) disable iff (!rst_b)
        s_rd_lower |=> (hrdata[REG_W-1:0] & LOWER_RO) == LOWER_RO
            && hrdata[DATA_W-1:REG_W] == '0;
    endproperty
    a_lower_ro_read: assert property (p_lower_ro_read)
        else $error("lower read-only bits not read as one");

    property p_upper_write;
        @(posedge mclk) disable iff (!rst_b)
        s_wr_upper |=> s_reg.upper_sel == (($past(hwdata[REG_W-1:0]) & ~UPPER_RO) | UPPER_RO);
    endproperty
    a_upper_write: assert property (p_upper_write)
        else $error("upper select write not stored");

    property p_bus_okay;
        @(posedge mclk) disable iff (!rst_b)
        accept |=> hreadyout && hresp == HRESP_OKAY;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus answer not ready and okay");
endmodule

// ==== testbench/pcfs_far_model.sv ====
// Purpose: Far-side model of the timer one-shot sources, DMA acknowledges and pad wires
// Assumes: Sources are flops on mclk; pads outside the chip have a fixed outside level
// Notes: The bench asks for source levels; the model launches them after an edge
`timescale 1ns/1ps
module pcfs_far_model
    import pcfs_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Requested levels from the bench
    input wire logic [UP_N-1:0] oneshot_req,
    input wire logic [1:0] dma_req,
    input wire logic [NUM_PINS-1:0] ext_level,
    // Block pads
    input wire logic [NUM_PINS-1:0] pad_out,
    input wire logic [NUM_PINS-1:0] pad_oe,
    output logic [NUM_PINS-1:0] pad_in,
    // Sources into the block
    output logic [UP_N-1:0] oneshot,
    output logic [1:0] dma_ack
);
    // ==========================================================
    // Sources
    // Launched after an edge, so the block never sees them change at its sampling edge
    always @(posedge mclk) begin
        oneshot <= oneshot_req;
        dma_ack <= dma_req;
    end

    // ==========================================================
    // Pad wire level
    // Block drive wins; an undriven pad shows the outside level, never the old drive
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

// ==== testbench/port_c_pin_function_select_tb.sv ====
// Purpose: Self-checking bench for the port C pin function select block
// Assumes: One AHB-Lite master, the block's hreadyout is the bus hready
// Notes: Pad checks sample at an edge, seeing values launched one edge earlier
`timescale 1ns/1ps
module port_c_pin_function_select_tb;
    import pcfs_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [DATA_W-1:0] haddr = '0;
    logic [1:0] htrans = HTRANS_IDLE;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [DATA_W-1:0] hwdata = '0;
    logic [DATA_W-1:0] hrdata;
    logic hreadyout;
    logic [1:0] hresp;
    logic [NUM_PINS-1:0] gpio_out = '0;
    logic [NUM_PINS-1:0] gpio_oe = '0;
    logic [NUM_PINS-1:0] gpio_in;
    logic [NUM_PINS-1:0] pad_in;
    logic [NUM_PINS-1:0] pad_out;
    logic [NUM_PINS-1:0] pad_oe;
    logic [NUM_PINS-1:0] ext_level = 15'h2AAA;
    logic [REG_W-1:0] lower_select;
    logic [UP_N-1:0] oneshot_req = '0;
    logic [UP_N-1:0] oneshot;
    logic [1:0] dma_req = '0;
    logic [1:0] dma_ack;
    int errors = 0;
    int samples_checked = 0;

    always #20 mclk = ~mclk;

    // ==========================================================
    // Design and far side
    pcfs_top dut (
        .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
        .oneshot_out_b(oneshot[0]), .oneshot_out_c(oneshot[1]), .oneshot_out_d(oneshot[2]),
        .oneshot_out_e(oneshot[3]), .oneshot_out_f(oneshot[4]), .oneshot_out_g(oneshot[5]),
        .oneshot_out_h(oneshot[6]), .dma_ack_out_zero(dma_ack[0]),
        .dma_ack_out_one(dma_ack[1]), .lower_select(lower_select),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe)
    );

    pcfs_far_model far (
        .mclk(mclk), .oneshot_req(oneshot_req), .dma_req(dma_req), .ext_level(ext_level),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in),
        .oneshot(oneshot), .dma_ack(dma_ack)
    );

    // ==========================================================
    // Compare tasks
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pad(input logic [14:0] got, input logic [14:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ==========================================================
    // Bus tasks
    // Address phase held until hready, then data phase held until hready
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0_0000, a};
        hwrite <= wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        chk_word(r, exp);
        chk_word({30'h0000_0000, hresp}, 32'h0000_0000);
    endtask

    // ==========================================================
    // Scenario helpers
    task automatic reset_check();
        rd_chk(UPPER_OFS, 32'h0000_C000);
        rd_chk(LOWER_OFS, 32'h0000_0BFF);
        chk_word({16'h0000, lower_select}, 32'h0000_0BFF);
    endtask

    // One select code on one upper pin, all other upper pins left at 00
    task automatic pin_case(input int p, input logic [1:0] code);
        logic [14:0] eo;
        logic [14:0] ee;
        wr_reg(UPPER_OFS, 32'(code) << (2 * (p - 8)));
        repeat (2) @(posedge mclk);
        // Sources are read only once settled, never in the step that sets them
        eo = gpio_out;
        ee = gpio_oe;
        if (code == 2'h1) begin
            eo[p] = oneshot_req[p - 8];
            ee[p] = 1'b1;
        end else if (code == 2'h2 && (p == 11 || p == 12)) begin
            eo[p] = dma_req[p - 11];
            ee[p] = 1'b1;
        end
        chk_pad(pad_out, eo);
        chk_pad(pad_oe, ee);
    endtask

    // ==========================================================
    // Closing
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        reset_check();
        $display("test reset values done");
        wr_reg(UPPER_OFS, 32'hFFFF_2AAA);
        rd_chk(UPPER_OFS, 32'h0000_EAAA);
        wr_reg(LOWER_OFS, 32'h0000_0000);
        rd_chk(LOWER_OFS, 32'h0000_0AAA);
        wr_reg(LOWER_OFS, 32'h0000_8400);
        rd_chk(LOWER_OFS, 32'h0000_8EAA);
        chk_word({16'h0000, lower_select}, 32'h0000_8EAA);
        wr_reg(LOWER_OFS, 32'hFFFF_5555);
        rd_chk(LOWER_OFS, 32'h0000_5FFF);
        wr_reg(12'h008, 32'hFFFF_FFFF);
        rd_chk(12'h008, 32'h0000_0000);
        rd_chk(LOWER_OFS, 32'h0000_5FFF);
        $display("test register access done");
        // Two source patterns so one-shot and generic drive always differ; DMA differs from each in one pass
        for (int k = 0; k < 2; k++) begin
            oneshot_req <= k ? 7'h00 : 7'h7F;
            // Acknowledge differs from generic drive in pass 0, from one-shot in pass 1
            dma_req <= 2'h3;
            gpio_out <= k ? 15'h7FFF : 15'h0000;
            gpio_oe <= k ? 15'h0000 : 15'h5555;
            for (int p = 8; p < 15; p++) begin
                for (int c = 0; c < 4; c++) begin
                    pin_case(p, 2'(c));
                end
            end
        end
        $display("test pin decode done");
        // Nothing driven now, so the pads show the outside level
        repeat (3) @(posedge mclk);
        chk_pad(gpio_in, ext_level);
        $display("test pad input done");
        wr_reg(UPPER_OFS, 32'h0000_1555);
        wr_reg(LOWER_OFS, 32'h0000_0000);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        reset_check();
        $display("test mid-run reset done");
        end_of_test();
    end

    // ==========================================================
    // Watchdog
    // Whole run needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        end_of_test();
    end
endmodule
